// ===== core/switch_cmd_pkg.sv
package switch_cmd_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;
    localparam int          CTRL_FUNC1_LSB  = 0;
    localparam int          CTRL_FUNC2_LSB  = 2;
    localparam int          CTRL_INV1_BIT   = 4;
    localparam int          CTRL_INV2_BIT   = 5;
    localparam int          STAT_LEVEL_LSB  = 0;
    localparam int          STAT_PIN_LSB    = 2;
    localparam int          STAT_CODE_LSB   = 4;
    localparam int          STAT_BUSY_BIT   = 6;

    // ----------------------------------------------------------------
    // port function encoding and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0]  FUNC_PASSIVE    = 2'h0;
    localparam logic [1:0]  FUNC_INPUT      = 2'h1;
    localparam logic [1:0]  FUNC_OUTPUT     = 2'h2;
    localparam logic [1:0]  FUNC_RESET      = FUNC_PASSIVE;
    localparam logic        INV_RESET       = 1'h0;
    localparam logic        LEVEL_RESET     = 1'h0;

    // ----------------------------------------------------------------
    // status codes of the set reply
    // ----------------------------------------------------------------
    localparam logic [1:0]  CODE_OK         = 2'h0;
    localparam logic [1:0]  CODE_SYNTAX     = 2'h1;
    localparam logic [1:0]  CODE_PARAM      = 2'h2;
    localparam logic [1:0]  CODE_OTHER      = 2'h3;

    // ----------------------------------------------------------------
    // characters and buffer sizes
    // ----------------------------------------------------------------
    localparam logic [7:0]  CH_O            = 8'h4F;
    localparam logic [7:0]  CH_A            = 8'h41;
    localparam logic [7:0]  CH_S            = 8'h53;
    localparam logic [7:0]  CH_I            = 8'h49;
    localparam logic [7:0]  CH_P            = 8'h50;
    localparam logic [7:0]  CH_0            = 8'h30;
    localparam logic [7:0]  CH_1            = 8'h31;
    localparam logic [7:0]  CH_2            = 8'h32;
    localparam logic [7:0]  CH_QUERY        = 8'h3F;
    localparam logic [7:0]  CH_SPACE        = 8'h20;
    localparam logic [7:0]  CH_EQ           = 8'h3D;
    localparam logic [7:0]  CH_SEMI         = 8'h3B;
    localparam logic [7:0]  CH_CR           = 8'h0D;
    localparam logic [7:0]  CH_LF           = 8'h0A;
    localparam int          LINE_MAX        = 16;
    localparam int          REPLY_MAX       = 14;
    localparam logic [4:0]  LEN_SHORT       = 5'h03;
    localparam logic [4:0]  LEN_BARE        = 5'h02;
    localparam logic [4:0]  LEN_ONE_FIELD   = 5'h07;
    localparam logic [4:0]  LEN_TWO_FIELDS  = 5'h0C;
    localparam logic [3:0]  QUERY_LEN       = 4'hE;
    localparam logic [3:0]  STATUS_LEN      = 4'h7;

endpackage

// ===== core/switch_output_command_handler.sv
`timescale 1ns/1ns
module switch_output_command_handler
    import switch_cmd_pkg::*;
(
    input  wire logic        clock,      // system clock, 100 MHz
    input  wire logic        srst,       // synchronous reset
    input  wire logic        ce,         // clock enable
    input  wire logic [7:0]  rx_data,    // command character
    input  wire logic        rx_valid,   // character strobe
    output logic             rx_ready,   // characters accepted
    output logic [7:0]       tx_data,    // reply character
    output logic             tx_valid,   // reply character valid
    input  wire logic        tx_ready,   // host takes reply character
    input  wire logic [7:0]  addr,       // register address
    input  wire logic [31:0] wdata,      // register write data
    input  wire logic        wr,         // write strobe
    input  wire logic        rd,         // read strobe
    output logic [31:0]      rdata,      // read data, cycle after rd
    output logic [1:0]       port_pin,   // physical port levels
    output logic [1:0]       port_drive  // port driven as output
);

    typedef struct packed {
        logic [LINE_MAX-1:0][7:0]  line;
        logic [4:0]                len;
        logic                      ovf;
        logic [REPLY_MAX-1:0][7:0] reply;
        logic [3:0]                rcount;
        logic                      tx_valid;
        logic                      rx_ready;
        logic [1:0][1:0]           func;
        logic [1:0]                inv;
        logic [1:0]                set_en;
        logic [1:0]                set_lvl;
        logic [1:0]                code;
        logic [31:0]               rdata;
    } core_s;

    core_s      st;
    core_s      next_st;
    logic [1:0] level;
    logic [1:0] pin;
    logic [1:0] drive;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic is_bit(input logic [7:0] c);
        return (c == CH_0) || (c == CH_1);
    endfunction

    // reply field of one port
    function automatic logic [7:0] field_char(input logic [1:0] f,
                                              input logic       l);
        logic [7:0] c;
        c = CH_P;
        if (f == FUNC_OUTPUT) begin
            c = l ? CH_1 : CH_0;
        end else if (f == FUNC_INPUT) begin
            c = CH_I;
        end
        return c;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [REPLY_MAX-1:0][7:0] r;
        logic [1:0]                req_en;
        logic [1:0]                req_val;
        logic [1:0]                code;
        logic                      is_set;
        logic                      idx;
        r       = '0;
        req_en  = '0;
        req_val = '0;
        code    = CODE_OK;
        is_set  = 1'b0;
        idx     = 1'b0;
        next_st = st;
        next_st.set_en = '0;
        next_st.rdata  = '0;

        // register bus: ctrl steers functions, status shows state
        if (wr && addr == ADDR_CTRL) begin
            next_st.func[0] = wdata[CTRL_FUNC1_LSB +: 2];
            next_st.func[1] = wdata[CTRL_FUNC2_LSB +: 2];
            next_st.inv[0]  = wdata[CTRL_INV1_BIT];
            next_st.inv[1]  = wdata[CTRL_INV2_BIT];
        end
        if (rd) begin
            if (addr == ADDR_CTRL) begin
                next_st.rdata[CTRL_FUNC1_LSB +: 2] = st.func[0];
                next_st.rdata[CTRL_FUNC2_LSB +: 2] = st.func[1];
                next_st.rdata[CTRL_INV1_BIT]       = st.inv[0];
                next_st.rdata[CTRL_INV2_BIT]       = st.inv[1];
            end else if (addr == ADDR_STATUS) begin
                next_st.rdata[STAT_LEVEL_LSB +: 2] = level;
                next_st.rdata[STAT_PIN_LSB +: 2]   = pin;
                next_st.rdata[STAT_CODE_LSB +: 2]  = st.code;
                next_st.rdata[STAT_BUSY_BIT]       = st.tx_valid;
            end
        end

        // reply shifts out low character first
        if (st.tx_valid && tx_ready) begin
            next_st.reply  = st.reply >> 8;
            next_st.rcount = st.rcount - 4'h1;
        end

        // line assembly; input is held off while a reply drains
        if (rx_valid && !st.tx_valid) begin
            if (rx_data == CH_CR || rx_data == CH_LF) begin
                next_st.len = '0;
                next_st.ovf = 1'b0;
                if (st.line[0] == CH_O && st.line[1] == CH_A &&
                    st.len >= LEN_BARE) begin
                    if (st.ovf) begin
                        is_set = 1'b1;
                        code   = CODE_OTHER;
                    end else if (st.len == LEN_SHORT) begin
                        if (st.line[2] == CH_QUERY) begin
                            r[0]  = CH_O;
                            r[1]  = CH_A;
                            r[2]  = CH_SPACE;
                            r[3]  = CH_S;
                            r[4]  = CH_1;
                            r[5]  = CH_EQ;
                            r[6]  = field_char(st.func[0], level[0]);
                            r[7]  = CH_SEMI;
                            r[8]  = CH_S;
                            r[9]  = CH_2;
                            r[10] = CH_EQ;
                            r[11] = field_char(st.func[1], level[1]);
                            r[12] = CH_CR;
                            r[13] = CH_LF;
                            next_st.reply  = r;
                            next_st.rcount = QUERY_LEN;
                        end else if (st.line[2] == CH_1 ||
                                     st.line[2] == CH_2) begin
                            // no reply; the driver drops non-outputs
                            idx = (st.line[2] == CH_2);
                            next_st.set_en[idx]  = 1'b1;
                            next_st.set_lvl[idx] = 1'b1;
                        end
                    end else begin
                        is_set = 1'b1;
                        if (st.len == LEN_BARE) begin
                            code = CODE_OK;
                        end else if (st.line[2] != CH_SPACE ||
                                     st.line[3] != CH_S ||
                                     st.line[5] != CH_EQ) begin
                            code = CODE_SYNTAX;
                        end else if (st.len == LEN_ONE_FIELD &&
                                     (st.line[4] == CH_1 ||
                                      st.line[4] == CH_2)) begin
                            idx          = (st.line[4] == CH_2);
                            req_en[idx]  = 1'b1;
                            req_val[idx] = (st.line[6] == CH_1);
                            code = is_bit(st.line[6]) ? CODE_OK
                                                      : CODE_PARAM;
                        end else if (st.len == LEN_TWO_FIELDS &&
                                     st.line[4] == CH_1 &&
                                     st.line[7] == CH_SEMI &&
                                     st.line[8] == CH_S &&
                                     st.line[9] == CH_2 &&
                                     st.line[10] == CH_EQ) begin
                            // fields out of order fail here
                            req_en  = 2'h3;
                            req_val = {st.line[11] == CH_1,
                                       st.line[6] == CH_1};
                            code = (is_bit(st.line[6]) &&
                                    is_bit(st.line[11])) ? CODE_OK
                                                         : CODE_PARAM;
                        end else begin
                            code = CODE_SYNTAX;
                        end
                    end
                end
                if (is_set) begin
                    // a rejected command changes no port
                    if (code == CODE_OK) begin
                        next_st.set_en  = req_en;
                        next_st.set_lvl = req_val;
                    end
                    next_st.code = code;
                    r[0] = CH_O;
                    r[1] = CH_A;
                    r[2] = CH_EQ;
                    r[3] = CH_0;
                    r[4] = CH_0 + {6'h00, code};
                    r[5] = CH_CR;
                    r[6] = CH_LF;
                    next_st.reply  = r;
                    next_st.rcount = STATUS_LEN;
                end
            end else if (st.len == LINE_MAX[4:0]) begin
                next_st.ovf = 1'b1; // long line answered as other error
            end else begin
                next_st.line[st.len[3:0]] = rx_data;
                next_st.len = st.len + 5'h01;
            end
        end
        next_st.tx_valid = (next_st.rcount != 4'h0);
        // own flop so the ready pin does not hang behind an inverter
        next_st.rx_ready = (next_st.rcount == 4'h0);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            st         <= '0;
            st.func[0] <= FUNC_RESET;
            st.func[1] <= FUNC_RESET;
            st.inv     <= {INV_RESET, INV_RESET};
            st.rx_ready <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // port drivers
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_port
        switch_port_driver u_port (
            .clock     (clock),
            .srst      (srst),
            .ce        (ce),
            .set_en    (st.set_en[i]),
            .set_level (st.set_lvl[i]),
            .func      (st.func[i]),
            .invert    (st.inv[i]),
            .level     (level[i]),
            .pin       (pin[i]),
            .drive     (drive[i])
        );
    end

    assign rx_ready   = st.rx_ready;
    assign tx_data    = st.reply[0];
    assign tx_valid   = st.tx_valid;
    assign rdata      = st.rdata;
    assign port_pin   = pin;
    assign port_drive = drive;

endmodule

// ===== core/switch_port_driver.sv
`timescale 1ns/1ns
module switch_port_driver
    import switch_cmd_pkg::*;
(
    input  wire logic       clock,      // system clock
    input  wire logic       srst,       // synchronous reset
    input  wire logic       ce,         // clock enable
    input  wire logic       set_en,     // one-cycle level update request
    input  wire logic       set_level,  // requested logical level
    input  wire logic [1:0] func,       // configured port function
    input  wire logic       invert,     // inverted logic enabled
    output logic            level,      // logical level held
    output logic            pin,        // physical output level
    output logic            drive       // port is driven as output
);

    typedef struct packed {
        logic level;
        logic pin;
        logic drive;
    } port_s;

    port_s st;
    port_s next_st;

    // ----------------------------------------------------------------
    // level and pin
    // ----------------------------------------------------------------
    // requests on a non-output port are dropped here, so the parser
    // does not need to know the function
    always_comb begin
        next_st = st;
        if (set_en && func == FUNC_OUTPUT) begin
            next_st.level = set_level;
        end
        next_st.drive = (func == FUNC_OUTPUT);
        next_st.pin   = next_st.drive & (next_st.level ^ invert);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st <= '{level: LEVEL_RESET, pin: 1'b0, drive: 1'b0};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign level = st.level;
    assign pin   = st.pin;
    assign drive = st.drive;

endmodule

// ===== testbench/host_model.sv
`timescale 1ns/1ns
module host_model (
    input  wire logic       clock,      // system clock
    input  wire logic       rx_ready,   // handler accepts characters
    input  wire logic [7:0] tx_data,    // reply character
    input  wire logic       tx_valid,   // reply character valid
    output logic      [7:0] rx_data,    // command character
    output logic            rx_valid,   // character strobe
    output logic            tx_ready    // reply character taken
);
    logic         slow;
    logic [127:0] reply;
    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
        slow     = 1'b0;
        reply    = '0;
    end
    // collect the reply; a slow host stalls every second cycle
    always @(posedge clock) begin
        if (tx_valid && tx_ready)
            reply <= {reply[119:0], tx_data};
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    // one pulse per character; fields come as the tests give them
    task send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clock);
            while (!rx_ready) @(posedge clock);
            rx_data  <= s[i];
            rx_valid <= 1'b1;
            @(posedge clock);
            rx_valid <= 1'b0;
            rx_data  <= ~s[i]; // released line shows no stale character
        end
    endtask
endmodule

// ===== testbench/switch_cmd_assertions.sv
`timescale 1ns/1ns
module switch_cmd_checker
    import switch_cmd_pkg::*;
(
    input wire logic        clock,      // system clock
    input wire logic        srst,       // synchronous reset
    input wire logic        rx_ready,   // characters accepted
    input wire logic [7:0]  tx_data,    // reply character
    input wire logic        tx_valid,   // reply character valid
    input wire logic        tx_ready,   // host takes reply character
    input wire logic [7:0]  addr,       // register address
    input wire logic [31:0] wdata,      // register write data
    input wire logic        wr,         // write strobe
    input wire logic        rd,         // read strobe
    input wire logic [31:0] rdata,      // read data
    input wire logic [1:0]  port_pin,   // physical port levels
    input wire logic [1:0]  port_drive  // ports driven
);
    logic [7:0] last_char;
    logic       xfer;
    // ----------------------------------------------------------------
    // helper: last reply character taken, to spot the status digits
    // ----------------------------------------------------------------
    assign xfer = tx_valid && tx_ready;
    always_ff @(posedge clock) begin
        if (srst)
            last_char <= 8'h00;
        else if (xfer)
            last_char <= tx_data;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // ----------------------------------------------------------------
    // reply link, register read and port checks
    // ----------------------------------------------------------------
    property p_first_char; $rose(tx_valid) |-> tx_data == CH_O; endproperty
    a_first_char: assert property (p_first_char)
        else $error("reply does not open with O");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("reply character dropped before taken");
    property p_rx_block; tx_valid |-> !rx_ready; endproperty
    a_rx_block: assert property (p_rx_block)
        else $error("commands accepted while replying");
    property p_lf; xfer && tx_data == CH_CR |=> tx_valid && tx_data == CH_LF;
    endproperty
    a_lf: assert property (p_lf)
        else $error("line feed missing after carriage return");
    property p_code; xfer && tx_data == CH_EQ && last_char == CH_A
        |=> tx_valid && tx_data == CH_0; endproperty
    a_code: assert property (p_code)
        else $error("status code does not start with 0");
    // a lag of one cycle between drive and pin is tolerated
    property p_undriven; !port_drive[0] [*2] |-> !port_pin[0]; endproperty
    a_undriven: assert property (p_undriven)
        else $error("undriven port shows a high pin");
    property p_drive; wr && addr == ADDR_CTRL && wdata[1:0] == FUNC_OUTPUT
        |-> ##[1:2] port_drive[0]; endproperty
    a_drive: assert property (p_drive)
        else $error("output function does not drive port");
    property p_unmapped; $past(rd) && $past(addr) != ADDR_CTRL
        && $past(addr) != ADDR_STATUS |-> rdata == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero");
    property p_reply_end; xfer && tx_data == CH_LF |=> !tx_valid && rx_ready;
    endproperty
    a_reply_end: assert property (p_reply_end)
        else $error("reply runs on after line feed");
endmodule
bind switch_output_command_handler switch_cmd_checker chk (.clock(clock),
    .srst(srst), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .port_pin(port_pin), .port_drive(port_drive));

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t value mismatch", $time); end end
module tb_top;
    import switch_cmd_pkg::*;
    logic        clock, srst, ce, wr, rd, rx_valid, rx_ready;
    logic        tx_valid, tx_ready;
    logic [7:0]  addr, rx_data, tx_data;
    logic [31:0] wdata, rdata;
    logic [1:0]  port_pin, port_drive;
    int          miscompares, check_count;

    switch_output_command_handler uut (.clock(clock), .srst(srst), .ce(ce),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .port_pin(port_pin), .port_drive(port_drive));
    host_model host (.clock(clock), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_ready(tx_ready));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ----------------------------------------------------------------
    // bus and command tasks
    // ----------------------------------------------------------------
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clock);
        wr    <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd   <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    // send a line, wait for the reply to end, check reply and ports
    task cmd(input string s, input logic [127:0] e, input logic [3:0] pd,
             input logic slow);
        host.slow  <= slow;
        host.reply <= '0;
        host.send(s);
        for (int i = 0; i < 80; i++) begin
            @(posedge clock);
            if (host.reply[15:0] === 16'h0D0A && tx_valid === 1'b0)
                break;
        end
        repeat (3) @(posedge clock);
        #1 `CHK(host.reply, e)
        `CHK({port_drive, port_pin}, pd)
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog sized well above the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        complete_run;
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        srst  = 1'b1;
        ce    = 1'b1; // freezing is tried once, on a register write
        wr    = 1'b0;
        rd    = 1'b0;
        addr  = 8'h00;
        wdata = 32'h0000_0000;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        rd_chk(ADDR_CTRL, 32'h0000_0000);
        rd_chk(ADDR_STATUS, 32'h0000_0000);
        wr_reg(ADDR_CTRL, 32'h0000_0006);
        cmd("OA?\015", "OA S1=0;S2=I\015\n", 4'h4, 1'b0);
        cmd("OA1\015", 128'h0, 4'h5, 1'b0);
        cmd("OA2\015", 128'h0, 4'h5, 1'b0);
        cmd("OA?\015", "OA S1=1;S2=I\015\n", 4'h5, 1'b1);
        cmd("OA S1=0;S2=1\015", "OA=00\015\n", 4'h4, 1'b0);
        wr_reg(ADDR_CTRL, 32'h0000_0016);
        cmd("OA S1=1\015", "OA=00\015\n", 4'h4, 1'b1);
        cmd("OA?\015", "OA S1=1;S2=I\015\n", 4'h4, 1'b0);
        cmd("OA S2=0;S1=0\015", "OA=01\015\n", 4'h4, 1'b0);
        cmd("OA S1=5\015", "OA=02\015\n", 4'h4, 1'b0);
        rd_chk(ADDR_STATUS, 32'h0000_0021);
        cmd("OA S1=0;S2=0;S1=0\015", "OA=03\015\n", 4'h4, 1'b0);
        wr_reg(ADDR_CTRL, 32'h0000_001A);
        cmd("OA S2=1\015", "OA=00\015\n", 4'hE, 1'b0);
        cmd("OA\015", "OA=00\015\n", 4'hE, 1'b0);
        rd_chk(ADDR_STATUS, 32'h0000_000B);
        // a write while the clock enable is low must not land
        ce <= 1'b0;
        wr_reg(ADDR_CTRL, 32'h0000_0000);
        ce <= 1'b1;
        rd_chk(ADDR_CTRL, 32'h0000_001A);
        // function code 3 is no defined function and reads as passive
        wr_reg(ADDR_CTRL, 32'h0000_000F);
        cmd("OA?\015", "OA S1=P;S2=P\015\n", 4'h0, 1'b0);
        wr_reg(ADDR_CTRL, 32'h0000_0000);
        cmd("OA?\015", "OA S1=P;S2=P\015\n", 4'h0, 1'b0);
        rd_chk(8'h08, 32'h0000_0000);
        complete_run;
    end
endmodule
